// *** logic/teio_pkg.sv ***
// Purpose: Shared constants, modes and carriers for the trigger and I/O block
// Assumes: Single camera clock, plain configuration ports
// Notes:   Times in microseconds are scaled by cycles per microsecond
`default_nettype none
package teio_pkg;
  localparam int LINES          = 6;
  localparam int IDX_W          = 3;
  localparam int US_W           = 16;
  localparam int CYC_W          = 24;
  localparam int SET_W          = 16;
  localparam int FAC_W          = 8;
  localparam int ML_W           = 12;
  localparam int GAP_W          = 8;
  localparam int POS_W          = 32;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int NS_PER_US      = 1000;
  localparam int CYC_PER_US_DEF = NS_PER_US / CLK_PERIOD_NS;
  localparam int MUL_GAP_DEF    = 1;
  // Synchroniser channel positions
  localparam int CH_CLHS        = 0;
  localparam int CH_A           = 1;
  localparam int CH_B           = 2;
  localparam int CH_IO          = 3;
  localparam int NCH            = CH_IO + LINES;
  localparam int LINE_ONE       = 0;

  typedef enum logic {ORIGIN_INTERNAL, ORIGIN_EXTERNAL} teio_origin_e;
  typedef enum logic [1:0] {PICK_CLHS, PICK_SHAFT, PICK_LINE1} teio_pick_e;
  typedef enum logic [1:0] {
    EDGE_LOW_TO_HIGH, EDGE_HIGH_TO_LOW, EDGE_EITHER
  } teio_edge_e;
  typedef enum logic {SENSE_CCW, SENSE_CW} teio_sense_e;
  typedef enum logic {POLICY_POSITION, POLICY_MOTION} teio_policy_e;
  typedef enum logic {ORDER_MUL_DIV, ORDER_DIV_MUL} teio_order_e;
  typedef enum logic [1:0] {LS_IDLE, LS_LEAD, LS_HIGH} teio_lstate_e;

  typedef struct packed {
    teio_origin_e           trigger_origin_kind;
    teio_pick_e             external_trigger_pick;
    teio_edge_e             trigger_edge_sense;
    teio_sense_e            shaft_forward_sense;
    teio_policy_e           shaft_pulse_policy;
    teio_order_e            shaft_scale_order;
    logic [FAC_W-1:0]       shaft_rate_mul;
    logic [FAC_W-1:0]       shaft_rate_div;
    logic [US_W-1:0]        sensor_fire_lag;
    logic [CYC_W-1:0]       internal_row_rate;
    logic [SET_W-1:0]       input_settle_time;
  } teio_trig_cfg_s;

  typedef struct packed {
    logic                   out_enable;
    logic                   out_drive_origin;
    logic                   out_static_level;
    logic                   line_polarity_flip;
    logic [US_W-1:0]        out_pulse_lead;
    logic [US_W-1:0]        out_pulse_width;
  } teio_line_cfg_s;

  localparam teio_line_cfg_s LINE_CFG_RST = '0;
endpackage
`default_nettype wire

// *** logic/teio_top.sv ***
// Purpose: Line trigger selection, shaft decoding, rescaling, delay and I/O
// Assumes: Pins are asynchronous; configuration is quasi-static
// Notes:   One pending sensor delay and one pulse per line at a time
`timescale 1ns/100ps
`default_nettype none
module teio_top #(
  parameter int CYC_PER_US = teio_pkg::CYC_PER_US_DEF,
  parameter int MUL_GAP    = teio_pkg::MUL_GAP_DEF
) (
  // Clock, reset, enable
  input  wire logic                        clock,
  input  wire logic                        rst_b,
  input  wire logic                        clk_en,
  // Trigger configuration
  input  wire teio_pkg::teio_trig_cfg_s    trig_cfg,
  // Per-line configuration port
  input  wire logic [teio_pkg::IDX_W-1:0]  io_line_index,
  input  wire teio_pkg::teio_line_cfg_s    line_cfg,
  input  wire logic                        line_cfg_write,
  input  wire logic                        line_level_sample,
  output logic                             line_level_readback,
  // Link and pins
  input  wire logic                        clhs_trigger,
  input  wire logic                        shaft_phase_a,
  input  wire logic                        shaft_phase_b,
  input  wire logic [teio_pkg::LINES-1:0]  io_line_in,
  output logic [teio_pkg::LINES-1:0]       io_line_out,
  output logic [teio_pkg::LINES-1:0]       io_line_oe,
  // Sensor side
  output logic                             sensor_trigger,
  output logic                             scan_reverse
);
  import teio_pkg::*;

  localparam logic [GAP_W-1:0] MUL_GAP_M1 = GAP_W'(MUL_GAP - 1);

  function automatic logic [CYC_W-1:0] us_to_cyc(input logic [US_W-1:0] us);
    us_to_cyc = CYC_W'(int'(us) * CYC_PER_US);
  endfunction

  // Returns {b_leads, a_leads} for one legal gray step; jumps give 0
  function automatic logic [1:0] quad_step(input logic [1:0] p,
                                           input logic [1:0] c);
    quad_step = 2'h0;
    if (c == {~p[0], p[1]}) begin
      quad_step = 2'h1;
    end else if (c == {p[0], ~p[1]}) begin
      quad_step = 2'h2;
    end
  endfunction

  function automatic logic [FAC_W-1:0] at_least_one(input logic [FAC_W-1:0] f);
    at_least_one = (f == '0) ? FAC_W'(1) : f;
  endfunction

  // Synchroniser, two flops per pin
  logic [NCH-1:0]   sync1_q;
  logic [NCH-1:0]   sync2_q;
  wire  [NCH-1:0]   raw_in = {io_line_in, shaft_phase_b, shaft_phase_a,
                              clhs_trigger};

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // Debounce, settle time in clock cycles
  logic [NCH-1:0]   deb_q;
  logic [SET_W-1:0] settle_cnt_q [NCH];
  wire  [SET_W-1:0] settle   = trig_cfg.input_settle_time;
  wire  [SET_W-1:0] settle_m1 = (settle == '0) ? '0 : settle - SET_W'(1);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      deb_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        settle_cnt_q[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (sync2_q[i] == deb_q[i]) begin
          settle_cnt_q[i] <= '0;
        end else if (settle_cnt_q[i] >= settle_m1) begin
          deb_q[i]        <= sync2_q[i];
          settle_cnt_q[i] <= '0;
        end else begin
          settle_cnt_q[i] <= settle_cnt_q[i] + SET_W'(1);
        end
      end
    end
  end

  // Line settings, stored by index
  teio_line_cfg_s   line_cfg_q [LINES];
  wire              idx_ok = (int'(io_line_index) < LINES);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LINES; i++) begin
        line_cfg_q[i] <= LINE_CFG_RST;
      end
    end else if (clk_en && line_cfg_write && idx_ok) begin
      line_cfg_q[io_line_index] <= line_cfg;
    end
  end

  logic [LINES-1:0] line_in_flip;
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      line_in_flip[i] = deb_q[CH_IO+i] ^ line_cfg_q[i].line_polarity_flip;
    end
  end

  // Quadrature decode and position tracking
  logic [1:0]              ab_q;
  logic signed [POS_W-1:0] pos_q;
  logic signed [POS_W-1:0] peak_q;
  logic                    dir_rev_q;
  wire  [1:0] ab_now   = {deb_q[CH_A], deb_q[CH_B]};
  wire  [1:0] step     = quad_step(ab_q, ab_now);
  wire        ccw      = (trig_cfg.shaft_forward_sense == SENSE_CCW);
  wire        step_fwd = ccw ? step[0] : step[1];
  wire        step_bck = ccw ? step[1] : step[0];
  wire        motion   = (trig_cfg.shaft_pulse_policy == POLICY_MOTION);
  wire        new_pos  = step_fwd && (pos_q == peak_q);
  wire        enc_pulse = motion ? (step_fwd || step_bck) : new_pos;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ab_q      <= '0;
      pos_q     <= '0;
      peak_q    <= '0;
      dir_rev_q <= 1'b0;
    end else if (clk_en) begin
      ab_q <= ab_now;
      if (step_fwd) begin
        pos_q     <= pos_q + POS_W'(1);
        dir_rev_q <= 1'b0;
      end else if (step_bck) begin
        pos_q     <= pos_q - POS_W'(1);
        dir_rev_q <= 1'b1;
      end
      if (new_pos) begin
        peak_q <= peak_q + POS_W'(1);
      end
    end
  end

  // Rescaler: divider and multiplier in either order
  logic [FAC_W-1:0] div_cnt_q;
  logic [ML_W-1:0]  mul_left_q;
  logic [GAP_W-1:0] gap_q;
  wire  mul_first = (trig_cfg.shaft_scale_order == ORDER_MUL_DIV);
  wire  [FAC_W-1:0] div_f = at_least_one(trig_cfg.shaft_rate_div);
  wire  [FAC_W-1:0] mul_f = at_least_one(trig_cfg.shaft_rate_mul);
  wire  mul_out = (mul_left_q != '0) && (gap_q == '0);
  wire  div_in  = mul_first ? mul_out : enc_pulse;
  wire  div_out = div_in && (div_cnt_q >= div_f - FAC_W'(1));
  wire  mul_in  = mul_first ? enc_pulse : div_out;
  wire  shaft_pulse = mul_first ? div_out : mul_out;
  wire  [ML_W-1:0] mul_left_d = mul_left_q - ML_W'(mul_out)
                                + (mul_in ? ML_W'(mul_f) : '0);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_q  <= '0;
      mul_left_q <= '0;
      gap_q      <= '0;
    end else if (clk_en) begin
      if (div_in) begin
        div_cnt_q <= div_out ? '0 : div_cnt_q + FAC_W'(1);
      end
      mul_left_q <= mul_left_d;
      if (mul_out) begin
        gap_q <= MUL_GAP_M1;
      end else if (gap_q != '0) begin
        gap_q <= gap_q - GAP_W'(1);
      end
    end
  end

  // Source pick, edge sense and internal rate
  logic             lvl_prev_q;
  logic [CYC_W-1:0] row_cnt_q;
  wire  pick_clhs = (trig_cfg.external_trigger_pick == PICK_CLHS);
  wire  pick_shaft = (trig_cfg.external_trigger_pick == PICK_SHAFT);
  wire  pick_line = (trig_cfg.external_trigger_pick == PICK_LINE1);
  wire  lvl = pick_clhs ? deb_q[CH_CLHS] : line_in_flip[LINE_ONE];
  wire  rise = lvl && !lvl_prev_q;
  wire  fall = !lvl && lvl_prev_q;
  wire  edge_hit = (trig_cfg.trigger_edge_sense == EDGE_LOW_TO_HIGH) ? rise :
                   (trig_cfg.trigger_edge_sense == EDGE_HIGH_TO_LOW) ? fall :
                   (trig_cfg.trigger_edge_sense == EDGE_EITHER) ? rise || fall
                   : 1'b0;
  wire  ext_trig = pick_shaft ? shaft_pulse :
                   (pick_clhs || pick_line) ? edge_hit : 1'b0;
  wire  [CYC_W-1:0] row_period = trig_cfg.internal_row_rate;
  wire  int_trig = (row_period != '0) &&
                   (row_cnt_q >= row_period - CYC_W'(1));
  wire  internal = (trig_cfg.trigger_origin_kind == ORIGIN_INTERNAL);
  wire  accepted = internal ? int_trig : ext_trig;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lvl_prev_q <= 1'b0;
      row_cnt_q  <= '0;
    end else if (clk_en) begin
      lvl_prev_q <= lvl;
      row_cnt_q  <= (int_trig || !internal) ? '0 : row_cnt_q + CYC_W'(1);
    end
  end

  // Sensor trigger lag
  logic             lag_busy_q;
  logic [CYC_W-1:0] lag_cnt_q;
  wire  [CYC_W-1:0] lag_cyc = us_to_cyc(trig_cfg.sensor_fire_lag);
  wire  start_lag = accepted && !lag_busy_q;
  wire  fire = (start_lag && lag_cyc == '0) ||
               (lag_busy_q && lag_cnt_q == '0);
  wire  scan_rev_d = !internal && pick_shaft && motion && dir_rev_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lag_busy_q     <= 1'b0;
      lag_cnt_q      <= '0;
      sensor_trigger <= 1'b0;
      scan_reverse   <= 1'b0;
    end else if (clk_en) begin
      sensor_trigger <= fire;
      scan_reverse   <= scan_rev_d;
      if (start_lag && lag_cyc != '0) begin
        lag_busy_q <= 1'b1;
        lag_cnt_q  <= lag_cyc - CYC_W'(1);
      end else if (lag_busy_q) begin
        lag_busy_q <= (lag_cnt_q != '0);
        lag_cnt_q  <= lag_cnt_q - CYC_W'(1);
      end
    end
  end

  // Output line pulse engines
  teio_lstate_e     line_st_q  [LINES];
  logic [CYC_W-1:0] line_cnt_q [LINES];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      io_line_out <= '0;
      io_line_oe  <= '0;
      for (int i = 0; i < LINES; i++) begin
        line_st_q[i]  <= LS_IDLE;
        line_cnt_q[i] <= '0;
      end
    end else if (clk_en) begin
      for (int i = 0; i < LINES; i++) begin
        io_line_oe[i]  <= line_cfg_q[i].out_enable;
        io_line_out[i] <= line_cfg_q[i].out_drive_origin ?
          ((line_st_q[i] == LS_HIGH) ^ line_cfg_q[i].line_polarity_flip) :
          line_cfg_q[i].out_static_level;
        case (line_st_q[i])
          LS_IDLE: begin
            if (fire && line_cfg_q[i].out_drive_origin) begin
              line_st_q[i]  <= LS_LEAD;
              line_cnt_q[i] <= us_to_cyc(line_cfg_q[i].out_pulse_lead);
            end
          end
          LS_LEAD: begin
            if (line_cnt_q[i] == '0) begin
              line_cnt_q[i] <= us_to_cyc(line_cfg_q[i].out_pulse_width);
              line_st_q[i]  <= (line_cfg_q[i].out_pulse_width == '0) ?
                               LS_IDLE : LS_HIGH;
            end else begin
              line_cnt_q[i] <= line_cnt_q[i] - CYC_W'(1);
            end
          end
          LS_HIGH: begin
            if (line_cnt_q[i] <= CYC_W'(1)) begin
              line_st_q[i]  <= LS_IDLE;
              line_cnt_q[i] <= '0;
            end else begin
              line_cnt_q[i] <= line_cnt_q[i] - CYC_W'(1);
            end
          end
          default: begin
            line_st_q[i] <= LS_IDLE;
          end
        endcase
      end
    end
  end

  // Readback of the selected line
  wire sel_level = !idx_ok ? 1'b0 :
                   io_line_oe[io_line_index] ? io_line_out[io_line_index] :
                   line_in_flip[io_line_index];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      line_level_readback <= 1'b0;
    end else if (clk_en && line_level_sample) begin
      line_level_readback <= sel_level;
    end
  end

  default clocking cb @(posedge clock iff clk_en); endclocking
  default disable iff (!rst_b);

  a_position_no_back: assert property (
    !motion && (pos_q < peak_q) |-> !enc_pulse)
    else $error("position trigger issued before passing turning point");
  a_motion_every_step: assert property (
    motion && (step_fwd || step_bck) |-> enc_pulse)
    else $error("motion step produced no shaft pulse");
  a_rise_edge_only: assert property (
    !internal && pick_line &&
    trig_cfg.trigger_edge_sense == EDGE_LOW_TO_HIGH && accepted
    |-> line_in_flip[LINE_ONE] && !lvl_prev_q)
    else $error("rising sense accepted a non-rising line");
  a_settle_hold: assert property (
    $changed(deb_q[CH_A]) |-> $past(settle_cnt_q[CH_A]) >= $past(settle_m1))
    else $error("input accepted before settle time");
  a_lag_start: assert property (
    start_lag && lag_cyc != '0 |=> lag_busy_q && !sensor_trigger)
    else $error("sensor trigger not delayed");
  a_lag_zero_fire: assert property (
    start_lag && lag_cyc == '0 |=> sensor_trigger)
    else $error("zero lag did not fire next cycle");
  a_div_needs_in: assert property (
    div_out && div_f == FAC_W'(2) |-> $past(div_in) || div_cnt_q == FAC_W'(1))
    else $error("divider fired without enough input pulses");
  a_mul_burst: assert property (
    mul_in && mul_left_q == '0 && gap_q <= GAP_W'(1) |=> mul_out)
    else $error("multiplier did not start its burst");
  a_static_level: assert property (
    !line_cfg_q[3].out_drive_origin ##1 !line_cfg_q[3].out_drive_origin
    |-> io_line_out[3] == $past(line_cfg_q[3].out_static_level))
    else $error("static level not driven on line four");
  a_pulse_end: assert property (
    line_st_q[2] == LS_HIGH && line_cnt_q[2] <= CYC_W'(1)
    |=> line_st_q[2] == LS_IDLE)
    else $error("output pulse outlived its width");
endmodule
`default_nettype wire

// *** sim/teio_partner.sv ***
// Purpose: Far-side model: shaft encoder, link trigger and line inputs
// Assumes: Pins change just after a rising clock edge
// Notes:   Each line or link change is held for a caller-given number of cycles; each shaft step for 12
`timescale 1ns/100ps
`default_nettype none
module teio_partner (
  // Clock
  input  wire logic                  clock,
  // Pins toward the block
  output logic                       clhs_trigger,
  output logic                       shaft_phase_a,
  output logic                       shaft_phase_b,
  output logic [teio_pkg::LINES-1:0] io_line_in
);
  import teio_pkg::*;
  initial begin
    clhs_trigger  = 1'b0;
    shaft_phase_a = 1'b0;
    shaft_phase_b = 1'b0;
    io_line_in    = '0;
  end
  // Pins 0 to 5 are lines, LINES is the link trigger
  task automatic pin(input int which, input logic v, input int hold);
    @(posedge clock);
    if (which == LINES) clhs_trigger <= v;
    else io_line_in[which] <= v;
    repeat (hold) @(posedge clock);
  endtask
  // All pins back to idle, shaft to phase 00; takes no clock
  task automatic park();
    clhs_trigger  <= 1'b0;
    shaft_phase_a <= 1'b0;
    shaft_phase_b <= 1'b0;
    io_line_in    <= '0;
  endtask
  // One legal gray step, A leading when a_lead is set
  task automatic step(input logic a_lead);
    @(posedge clock);
    shaft_phase_a <= a_lead ? ~shaft_phase_b : shaft_phase_b;
    shaft_phase_b <= a_lead ? shaft_phase_a : ~shaft_phase_a;
    repeat (12) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// *** sim/teio_top_bench.sv ***
// Purpose: Self-checking bench for the trigger and I/O block
// Assumes: Partner model drives all pins; clock enable mostly high
// Notes:   Sensor pulses are counted by a free-running monitor
`timescale 1ns/100ps
`default_nettype none
module teio_top_bench;
  import teio_pkg::*;
  localparam int CPU = 10;
  localparam teio_trig_cfg_s TC0 = '{ORIGIN_EXTERNAL, PICK_LINE1,
    EDGE_LOW_TO_HIGH, SENSE_CCW, POLICY_MOTION, ORDER_MUL_DIV, 8'h01,
    8'h01, 16'h0000, 24'h000000, 16'h0001};
  logic             clock, rst_b, wr, smp, rdbk, strig, srev;
  logic             clhs, ph_a, ph_b, cen;
  logic [IDX_W-1:0] idx;
  logic [LINES-1:0] io_in, io_out, io_oe;
  teio_trig_cfg_s   tc;
  teio_line_cfg_s   lc;
  int               num_errors, tests_run, trig_n;

  teio_top #(.CYC_PER_US(CPU)) i_teio_top (
    .clock(clock), .rst_b(rst_b), .clk_en(cen), .trig_cfg(tc),
    .io_line_index(idx), .line_cfg(lc), .line_cfg_write(wr),
    .line_level_sample(smp), .line_level_readback(rdbk),
    .clhs_trigger(clhs), .shaft_phase_a(ph_a), .shaft_phase_b(ph_b),
    .io_line_in(io_in), .io_line_out(io_out), .io_line_oe(io_oe),
    .sensor_trigger(strig), .scan_reverse(srev));
  teio_partner i_teio_partner (
    .clock(clock), .clhs_trigger(clhs), .shaft_phase_a(ph_a),
    .shaft_phase_b(ph_b), .io_line_in(io_in));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (strig === 1'b1) trig_n++;

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    tc <= TC0;
    // Shaft parked so no false step follows the release
    i_teio_partner.park();
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task automatic wcfg(input logic [2:0] i, input logic en, org, lvl, flp,
                      input logic [15:0] ld, wd);
    @(posedge clock);
    idx <= i;
    lc <= '{en, org, lvl, flp, ld, wd};
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic steps(input int n, input logic a);
    repeat (n) i_teio_partner.step(a);
    @(negedge clock);
  endtask
  task automatic sample(input logic [2:0] i, input logic e, input string w);
    @(posedge clock);
    idx <= i;
    smp <= 1'b1;
    @(posedge clock);
    smp <= 1'b0;
    @(negedge clock);
    chk(w, rdbk, e);
  endtask
  // Line one rise; cycles until the sensor fires
  task automatic meas(output int d);
    d = 0;
    fork
      i_teio_partner.pin(0, 1'b1, 60);
      while (strig !== 1'b1 && d < 60) begin
        @(negedge clock);
        d++;
      end
    join
    i_teio_partner.pin(0, 1'b0, 60);
  endtask
  // Lead and width of the line three pulse at level pol
  task automatic pulse(input logic pol, output int a, output int w);
    a = 0;
    w = 0;
    fork
      i_teio_partner.pin(0, 1'b1, 60);
      begin
        repeat (60) begin
          @(negedge clock);
          if (strig === 1'b1) break;
        end
        while (io_out[2] !== pol && a < 60) begin
          @(negedge clock);
          a++;
        end
        while (io_out[2] === pol && w < 60) begin
          @(negedge clock);
          w++;
        end
      end
    join
    i_teio_partner.pin(0, 1'b0, 30);
  endtask

  task automatic t_pick();
    int n0;
    do_reset();
    tc.external_trigger_pick <= PICK_CLHS;
    n0 = trig_n;
    i_teio_partner.pin(LINES, 1'b1, 20);
    i_teio_partner.pin(LINES, 1'b0, 20);
    i_teio_partner.pin(0, 1'b1, 20);
    i_teio_partner.pin(0, 1'b0, 20);
    chk("pick_link", trig_n - n0, 1);
    tc.trigger_origin_kind <= ORIGIN_INTERNAL;
    tc.internal_row_rate <= 24'h000032;
    n0 = trig_n;
    repeat (500) @(posedge clock);
    chk("row_rate", (trig_n - n0) inside {[9:11]}, 1);
  endtask
  task automatic t_edges();
    int n0;
    for (int f = 0; f < 2; f++) begin
      for (int e = 0; e < 3; e++) begin
        do_reset();
        tc.trigger_edge_sense <= teio_edge_e'(e);
        wcfg(3'h0, 1'b0, 1'b0, 1'b0, f[0], 16'h0000, 16'h0000);
        n0 = trig_n;
        i_teio_partner.pin(0, 1'b1, 30);
        chk("rise", trig_n - n0, e == 2 || e == f);
        n0 = trig_n;
        i_teio_partner.pin(0, 1'b0, 30);
        chk("fall", trig_n - n0, e == 2 || e == 1 - f);
      end
    end
  endtask
  task automatic t_shaft();
    int n0;
    for (int s = 0; s < 2; s++) begin
      do_reset();
      tc.external_trigger_pick <= PICK_SHAFT;
      tc.shaft_forward_sense <= teio_sense_e'(s);
      n0 = trig_n;
      steps(4, 1'b1);
      chk("dir_a", srev, s[0]);
      steps(3, 1'b0);
      chk("dir_b", srev, !s[0]);
      chk("motion", trig_n - n0, 7);
    end
    do_reset();
    tc.external_trigger_pick <= PICK_SHAFT;
    tc.shaft_pulse_policy <= POLICY_POSITION;
    tc.shaft_forward_sense <= SENSE_CW;
    n0 = trig_n;
    steps(3, 1'b0);
    chk("pos_fwd", trig_n - n0, 3);
    n0 = trig_n;
    steps(2, 1'b1);
    steps(2, 1'b0);
    chk("pos_back", trig_n - n0, 0);
    steps(2, 1'b0);
    chk("pos_new", trig_n - n0, 2);
  endtask
  task automatic t_scale();
    int n0;
    int mt[4] = '{4, 1, 3, 3};
    int dt[4] = '{1, 3, 2, 2};
    int st[4] = '{2, 6, 3, 3};
    int et[4] = '{8, 2, 4, 3};
    for (int k = 0; k < 4; k++) begin
      do_reset();
      tc.external_trigger_pick <= PICK_SHAFT;
      tc.shaft_rate_mul <= mt[k][7:0];
      tc.shaft_rate_div <= dt[k][7:0];
      tc.shaft_scale_order <= teio_order_e'(k == 3);
      n0 = trig_n;
      steps(st[k], 1'b1);
      chk("rescale", trig_n - n0, et[k]);
    end
  endtask
  task automatic t_lag();
    int d0;
    int d2;
    do_reset();
    meas(d0);
    tc.sensor_fire_lag <= 16'h0002;
    meas(d2);
    chk("lag", d2 - d0, 2 * CPU);
  endtask
  task automatic t_lines();
    int a;
    int w;
    do_reset();
    wcfg(3'h3, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk("static", {io_out, io_oe}, 12'h208);
    wcfg(3'h6, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk("index_six", io_oe, 6'h08);
    wcfg(3'h2, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0001, 16'h0002);
    pulse(1'b1, a, w);
    chk("lead", a >= CPU && a <= CPU + 3, 1);
    chk("width", w >= 2 * CPU - 1 && w <= 2 * CPU + 1, 1);
    wcfg(3'h2, 1'b1, 1'b1, 1'b0, 1'b1, 16'h0001, 16'h0002);
    chk("flip_idle", io_out, 6'h0C);
    pulse(1'b0, a, w);
    chk("flip_w", w >= 2 * CPU - 1 && w <= 2 * CPU + 1, 1);
    sample(3'h3, 1'b1, "rb_driven");
    i_teio_partner.pin(4, 1'b1, 10);
    sample(3'h4, 1'b1, "rb_in");
    wcfg(3'h4, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000);
    sample(3'h4, 1'b0, "rb_flip");
  endtask
  task automatic t_settle();
    int n0;
    do_reset();
    tc.input_settle_time <= 16'h0014;
    n0 = trig_n;
    i_teio_partner.pin(0, 1'b1, 10);
    i_teio_partner.pin(0, 1'b0, 40);
    chk("glitch", trig_n - n0, 0);
    i_teio_partner.pin(0, 1'b1, 30);
    i_teio_partner.pin(0, 1'b0, 40);
    chk("settled", trig_n - n0, 1);
  endtask

  task automatic t_freeze();
    int n0;
    do_reset();
    cen <= 1'b0;
    n0 = trig_n;
    i_teio_partner.pin(0, 1'b1, 30);
    chk("frozen", trig_n - n0, 0);
    cen <= 1'b1;
    repeat (10) @(posedge clock);
    chk("thawed", trig_n - n0, 1);
    i_teio_partner.pin(0, 1'b0, 10);
  endtask

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    wr = 1'b0;
    smp = 1'b0;
    cen = 1'b1;
    idx = '0;
    lc = '0;
    tc = TC0;
    num_errors = 0;
    tests_run = 0;
    trig_n = 0;
    do_reset();
    @(negedge clock);
    chk("reset_out", {io_out, io_oe, strig, rdbk}, 14'h0000);
    t_pick();
    t_edges();
    t_shaft();
    t_scale();
    t_lag();
    t_lines();
    t_settle();
    t_freeze();
    stop_test();
  end
endmodule
`default_nettype wire
